//--- rtl/svm_pkg.sv
// constants, field layouts and types of the supply voltage monitor control
package svm_pkg;

   // =====================================================
   // timing
   localparam int unsigned CLK_FREQ_MHZ   = 200;
   localparam int unsigned MIN_ON_TIME_US = 500;
   // least time rounds up; the product is already whole cycles
   localparam int unsigned MIN_ON_CYCLES  = MIN_ON_TIME_US * CLK_FREQ_MHZ;
   localparam int          ON_CNT_W       = 17;

   // =====================================================
   // register indices; byte address is four times the index
   localparam logic [15:0] CTRL_IDX     = 16'hff12;
   localparam logic [15:0] HEAVY_IDX    = 16'hff10;
   localparam logic [15:0] IRQ_STAT_IDX = 16'hff13;
   localparam logic [15:0] IRQ_CLR_IDX  = 16'hff14;
   localparam logic [15:0] IRQ_EN_IDX   = 16'hff15;
   localparam logic [31:0] CTRL_ADDR     = {14'h0000, CTRL_IDX, 2'h0};
   localparam logic [31:0] HEAVY_ADDR    = {14'h0000, HEAVY_IDX, 2'h0};
   localparam logic [31:0] IRQ_STAT_ADDR = {14'h0000, IRQ_STAT_IDX, 2'h0};
   localparam logic [31:0] IRQ_CLR_ADDR  = {14'h0000, IRQ_CLR_IDX, 2'h0};
   localparam logic [31:0] IRQ_EN_ADDR   = {14'h0000, IRQ_EN_IDX, 2'h0};

   // =====================================================
   // field positions
   localparam int THR_LSB    = 0;
   localparam int THR_W      = 4;
   localparam int DET_ON_BIT = 4;
   localparam int RESULT_BIT = 5;
   localparam int HEAVY_BIT  = 7;

   // lowest threshold code with a defined level
   localparam logic [3:0] THR_MIN_DEFINED = 4'h3;

   // =====================================================
   // reset values
   localparam logic [3:0] THR_RESET    = 4'h0;
   localparam logic       DET_RESET    = 1'b0;
   localparam logic       RESULT_RESET = 1'b0;
   localparam logic       HEAVY_RESET  = 1'b0;

   // =====================================================
   // interrupt events
   localparam int         EV_W       = 3;
   localparam int         EV_CAPTURE = 0;
   localparam int         EV_LOW     = 1;
   localparam int         EV_SETTLED = 2;
   localparam logic [2:0] EV_RESET   = 3'h0;

   // =====================================================
   // types
   typedef struct packed {
      logic       heavy;
      logic       det_on;
      logic [3:0] thr;
   } svm_ctrl_t;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic [7:0]  wdata;
      logic        lane0;
   } svm_req_t;

   typedef enum logic [2:0] {
      SVM_OFF    = 3'b001,
      SVM_SETTLE = 3'b010,
      SVM_READY  = 3'b100
   } svm_state_t;

endpackage : svm_pkg

//--- rtl/svm_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module svm_sync (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      sync_o
);

   logic meta_reg;
   logic sync_reg;

   // =====================================================
   // first stage feeds only the second
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule : svm_sync

`default_nettype wire

//--- rtl/svm_irq.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/100ps
`default_nettype none

module svm_irq
   import svm_pkg::*;
(
   input  wire logic            clock_i,
   input  wire logic            rst_i,
   input  wire logic [EV_W-1:0] set_i,
   input  wire logic            clr_we_i,
   input  wire logic [EV_W-1:0] clr_data_i,
   input  wire logic            en_we_i,
   input  wire logic [EV_W-1:0] en_data_i,
   output logic      [EV_W-1:0] status_o,
   output logic      [EV_W-1:0] enable_o,
   output logic                 irq_o
);

   logic [EV_W-1:0] status_reg;
   logic [EV_W-1:0] status_next;
   logic [EV_W-1:0] enable_reg;
   logic [EV_W-1:0] enable_next;

   // =====================================================
   // set wins over a clear in the same cycle
   always_comb begin
      status_next = status_reg;
      enable_next = enable_reg;
      if (clr_we_i) begin
         status_next = status_next & ~clr_data_i;
      end
      status_next = status_next | set_i;
      if (en_we_i) begin
         enable_next = en_data_i;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         status_reg <= EV_RESET;
         enable_reg <= EV_RESET;
      end else begin
         status_reg <= status_next;
         enable_reg <= enable_next;
      end
   end

   assign status_o = status_reg;
   assign enable_o = enable_reg;
   assign irq_o    = |(status_reg & enable_reg);

endmodule : svm_irq

`default_nettype wire

//--- rtl/svm_ctrl.sv
// supply voltage monitor and heavy-load mode control with apb registers
`timescale 1ns/100ps
`default_nettype none

module svm_ctrl
   import svm_pkg::*;
#(
   parameter int unsigned MIN_ON_CNT = MIN_ON_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // analog detector side
   input  wire logic        comp_low_i,
   output logic             detector_enable_o,
   output logic      [3:0]  threshold_o,
   output logic             threshold_defined_o,
   output logic             heavy_load_mode_o,
   output logic             irq_o
);

   // =====================================================
   // declarations
   svm_ctrl_t          ctrl_reg;
   svm_ctrl_t          ctrl_next;
   logic               result_reg;
   logic               result_next;
   svm_state_t         state_reg;
   svm_state_t         state_next;
   logic [ON_CNT_W-1:0] on_cnt_reg;
   logic [ON_CNT_W-1:0] on_cnt_next;
   logic [31:0]        rdata_reg;
   logic [31:0]        rdata_next;
   logic               err_reg;
   logic               err_next;

   svm_req_t           req;
   logic               setup;
   logic               access;
   logic               wr;
   logic               hit_ctrl;
   logic               hit_heavy;
   logic               hit_stat;
   logic               hit_clr;
   logic               hit_en;
   logic               hit_any;
   logic               wr_ctrl;
   logic               wr_heavy;
   logic               det_on_wr;
   logic               det_off_wr;
   logic               comp_low_sync;
   logic               on_done;
   logic [EV_W-1:0]    ev_set;
   logic [EV_W-1:0]    irq_status;
   logic [EV_W-1:0]    irq_enable;
   logic [7:0]         ctrl_view;
   logic [7:0]         heavy_view;

   // =====================================================
   // comparator crossing
   // the comparator is unclocked analog; read only its
   // synchronised copy
   svm_sync u_comp_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i (comp_low_i),
      .sync_o  (comp_low_sync)
   );

   // =====================================================
   // apb request decode
   // the request is bundled once so decode reads one source
   always_comb begin
      req.addr  = paddr_i;
      req.write = pwrite_i;
      req.wdata = pwdata_i[7:0];
      req.lane0 = pstrb_i[0];
   end

   assign setup  = psel_i & ~penable_i;
   assign access = psel_i & penable_i;

   // address match against the full byte address
   assign hit_ctrl  = (req.addr == CTRL_ADDR);
   assign hit_heavy = (req.addr == HEAVY_ADDR);
   assign hit_stat  = (req.addr == IRQ_STAT_ADDR);
   assign hit_clr   = (req.addr == IRQ_CLR_ADDR);
   assign hit_en    = (req.addr == IRQ_EN_ADDR);
   assign hit_any   = hit_ctrl | hit_heavy | hit_stat | hit_clr | hit_en;

   // writes land only at the completing access edge
   // only byte lane 0 carries register bits
   assign wr       = access & req.write & hit_any & req.lane0;
   assign wr_ctrl  = wr & hit_ctrl;
   assign wr_heavy = wr & hit_heavy;

   // edges of the detector_on bit caused by software
   assign det_on_wr  = wr_ctrl & req.wdata[DET_ON_BIT] & ~ctrl_reg.det_on;
   assign det_off_wr = wr_ctrl & ~req.wdata[DET_ON_BIT] & ctrl_reg.det_on;

   // =====================================================
   // control register next state
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         // bits 7..5 of the write are dropped here
         ctrl_next.thr    = req.wdata[THR_LSB +: THR_W];
         ctrl_next.det_on = req.wdata[DET_ON_BIT];
      end
      if (wr_heavy) begin
         // one bit steers the mode both ways
         ctrl_next.heavy = req.wdata[HEAVY_BIT];
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg.thr    <= THR_RESET;
         ctrl_reg.det_on <= DET_RESET;
         ctrl_reg.heavy  <= HEAVY_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // =====================================================
   // result latch
   // capture at the same edge that switches the detector off,
   // so the comparator is still powered when sampled
   always_comb begin
      result_next = result_reg;
      if (det_off_wr) begin
         result_next = comp_low_sync;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         result_reg <= RESULT_RESET;
      end else begin
         result_reg <= result_next;
      end
   end

   // =====================================================
   // measurement sequencer
   // tracks the on time so software can see when the
   // comparator has settled; the capture itself never waits
   assign on_done = (on_cnt_reg >= MIN_ON_CNT[ON_CNT_W-1:0] - 1'b1);

   always_comb begin
      state_next  = state_reg;
      on_cnt_next = on_cnt_reg;
      case (state_reg)
         SVM_OFF: begin
            on_cnt_next = '0;
            if (det_on_wr) begin
               state_next = SVM_SETTLE;
            end
         end
         SVM_SETTLE: begin
            if (det_off_wr) begin
               state_next  = SVM_OFF;
               on_cnt_next = '0;
            end else if (on_done) begin
               state_next = SVM_READY;
            end else begin
               on_cnt_next = on_cnt_reg + 1'b1;
            end
         end
         SVM_READY: begin
            if (det_off_wr) begin
               state_next  = SVM_OFF;
               on_cnt_next = '0;
            end
         end
         default: begin
            state_next  = SVM_OFF;
            on_cnt_next = '0;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg  <= SVM_OFF;
         on_cnt_reg <= '0;
      end else begin
         state_reg  <= state_next;
         on_cnt_reg <= on_cnt_next;
      end
   end

   // =====================================================
   // interrupt events
   // capture and low result pulse with the latch update;
   // settled pulses at most once per on period
   always_comb begin
      ev_set             = '0;
      ev_set[EV_CAPTURE] = det_off_wr;
      ev_set[EV_LOW]     = det_off_wr & comp_low_sync;
      ev_set[EV_SETTLED] = (state_reg == SVM_SETTLE) & on_done & ~det_off_wr;
   end

   svm_irq u_irq (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .set_i      (ev_set),
      .clr_we_i   (wr & hit_clr),
      .clr_data_i (req.wdata[EV_W-1:0]),
      .en_we_i    (wr & hit_en),
      .en_data_i  (req.wdata[EV_W-1:0]),
      .status_o   (irq_status),
      .enable_o   (irq_enable),
      .irq_o      (irq_o)
   );

   // =====================================================
   // read views
   // result is only ever written by the capture path
   always_comb begin
      ctrl_view                     = 8'h00;
      ctrl_view[THR_LSB +: THR_W]   = ctrl_reg.thr;
      ctrl_view[DET_ON_BIT]         = ctrl_reg.det_on;
      ctrl_view[RESULT_BIT]         = result_reg;
      heavy_view                    = 8'h00;
      heavy_view[HEAVY_BIT]         = ctrl_reg.heavy;
   end

   // =====================================================
   // apb read data and error
   // taken in the setup cycle so prdata is a flop output
   // during access; a write in the previous access has
   // already landed by then
   always_comb begin
      rdata_next = rdata_reg;
      err_next   = err_reg;
      if (setup) begin
         rdata_next = 32'h0000_0000;
         err_next   = ~hit_any;
         if (~req.write) begin
            if (hit_ctrl) begin
               rdata_next[7:0] = ctrl_view;
            end else if (hit_heavy) begin
               rdata_next[7:0] = heavy_view;
            end else if (hit_stat) begin
               rdata_next[EV_W-1:0] = irq_status;
            end else if (hit_en) begin
               rdata_next[EV_W-1:0] = irq_enable;
            end
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // zero wait states: every access completes at once
   assign pready_o  = access;
   assign prdata_o  = rdata_reg;
   assign pslverr_o = access & err_reg;

   // =====================================================
   // detector drive
   // codes below three have no level; the flag lets the
   // analog side hold its reference safe
   assign detector_enable_o   = ctrl_reg.det_on;
   assign threshold_o         = ctrl_reg.thr;
   assign threshold_defined_o = (ctrl_reg.thr >= THR_MIN_DEFINED);
   assign heavy_load_mode_o   = ctrl_reg.heavy;

endmodule : svm_ctrl

`default_nettype wire

//--- tb/svm_ctrl_assertions.sv
// concurrent checks on the ports of the supply monitor control block
`timescale 1ns/100ps
`default_nettype none

module svm_ctrl_assertions
   import svm_pkg::*;
#(
   parameter int unsigned MIN_ON_CNT = MIN_ON_CYCLES
) (
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        comp_low_i,
   input wire logic        detector_enable_o,
   input wire logic [3:0]  threshold_o,
   input wire logic        threshold_defined_o,
   input wire logic        heavy_load_mode_o,
   input wire logic        irq_o
);
   // =====================================================
   // decoded accesses; strobe lane 0 gates every write
   wire logic acc_w   = psel_i && penable_i && pwrite_i && pstrb_i[0];
   wire logic ctrl_w  = acc_w && (paddr_i == CTRL_ADDR);
   wire logic heavy_w = acc_w && (paddr_i == HEAVY_ADDR);
   wire logic ctrl_r  = psel_i && penable_i && !pwrite_i && (paddr_i == CTRL_ADDR);

   // =====================================================
   // one clock domain, so one default clock and reset
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   property p_thr_wr;
      ctrl_w |=> threshold_o == $past(pwdata_i[3:0]);
   endproperty
   a_thr_wr: assert property (p_thr_wr) else $error("threshold not loaded");

   property p_thr_def;
      threshold_defined_o == (threshold_o >= THR_MIN_DEFINED);
   endproperty
   a_thr_def: assert property (p_thr_def) else $error("defined flag wrong");

   property p_on;
      ctrl_w && pwdata_i[DET_ON_BIT] |=> detector_enable_o;
   endproperty
   a_on: assert property (p_on) else $error("detector not powered");

   // detector drops at the same edge that captures the result
   property p_off;
      detector_enable_o && ctrl_w && !pwdata_i[DET_ON_BIT] |=> !detector_enable_o;
   endproperty
   a_off: assert property (p_off) else $error("detector not switched off");

   property p_stay;
      detector_enable_o && !ctrl_w && !$past(ctrl_w) |=> detector_enable_o;
   endproperty
   a_stay: assert property (p_stay) else $error("detector dropped on its own");

   property p_heavy;
      heavy_w |=> heavy_load_mode_o == $past(pwdata_i[HEAVY_BIT]);
   endproperty
   a_heavy: assert property (p_heavy) else $error("heavy mode not loaded");

   property p_rd_ctrl;
      ctrl_r |-> prdata_o[31:6] == 26'h0 && prdata_o[3:0] == threshold_o;
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl read wrong");

   property p_rst;
      $fell(rst_i) |-> threshold_o == 4'h0 && !detector_enable_o && !heavy_load_mode_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");

endmodule : svm_ctrl_assertions

bind svm_ctrl svm_ctrl_assertions #(.MIN_ON_CNT(MIN_ON_CNT)) i_svm_ctrl_assertions (
   .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .comp_low_i(comp_low_i), .detector_enable_o(detector_enable_o),
   .threshold_o(threshold_o), .threshold_defined_o(threshold_defined_o),
   .heavy_load_mode_o(heavy_load_mode_o), .irq_o(irq_o));

`default_nettype wire

//--- tb/testbench.sv
// self-checking testbench of the supply monitor control block
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import svm_pkg::*;

   // =====================================================
   // signals; small on-time keeps the run short
   localparam int unsigned MIN_ON = 8;
   logic        clock_i, rst_i, psel_i, penable_i, pwrite_i, comp_low_i;
   logic [31:0] paddr_i, pwdata_i, prdata_o, rdat, lfsr_q;
   logic [3:0]  pstrb_i, threshold_o, t;
   logic        pready_o, pslverr_o, detector_enable_o, threshold_defined_o;
   logic        heavy_load_mode_o, irq_o, rerr, v;
   int          fail_count, checks;

   svm_ctrl #(.MIN_ON_CNT(MIN_ON)) i_svm_ctrl (
      .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .comp_low_i(comp_low_i), .detector_enable_o(detector_enable_o),
      .threshold_o(threshold_o), .threshold_defined_o(threshold_defined_o),
      .heavy_load_mode_o(heavy_load_mode_o), .irq_o(irq_o));

   // 200 mhz clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   // =====================================================
   // expectations
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [31:0] ctrl_exp(input logic [3:0] th, input logic on, input logic r);
      return {26'h0, r, on, th};
   endfunction : ctrl_exp

   // =====================================================
   // bus and check tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
      end
   endtask : chk

   // one apb transfer; an idle edge after it avoids double drives
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      pstrb_i   <= s;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 100);
      if (n >= 100) chk(1'b0, 1'b1, "no pready");
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask : apb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask : wr

   task automatic rd(input logic [31:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask : rd

   task automatic reset_check();
      rd(CTRL_ADDR);
      chk(rdat, 32'h0, "ctrl after reset");
      rd(HEAVY_ADDR);
      chk(rdat, 32'h0, "heavy after reset");
      rd(IRQ_STAT_ADDR);
      chk(rdat, 32'h0, "status after reset");
      chk(detector_enable_o, 1'b0, "detector after reset");
      chk(irq_o, 1'b0, "irq after reset");
      $display("test reset done");
   endtask : reset_check

   task give_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // watchdog, far beyond the few hundred cycles needed
   initial begin
      #50000;
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end

   // =====================================================
   // main sequence
   initial begin
      {psel_i, penable_i, pwrite_i, comp_low_i} = 4'h0;
      {paddr_i, pwdata_i, pstrb_i} = 68'h0;
      rst_i = 1'b1;
      fail_count = 0;
      checks = 0;
      lfsr_q = 32'hee9b;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      reset_check();
      // every code, random junk in unused bits and a one in the read-only bit
      for (int c = 0; c < 16; c++) begin
         lfsr_q = lfsr_next(lfsr_q);
         wr(CTRL_ADDR, {lfsr_q[31:6], 2'h2, c[3:0]});
         chk(threshold_o, c[3:0], "threshold out");
         chk(threshold_defined_o, c >= 3, "defined flag");
         rd(CTRL_ADDR);
         chk(rdat, ctrl_exp(c[3:0], 1'b0, 1'b0), "ctrl read");
      end
      $display("test thresholds done");
      // measurements; comparator flips right after each capture
      wr(IRQ_EN_ADDR, 32'h7);
      for (int k = 0; k < 4; k++) begin
         lfsr_q = lfsr_next(lfsr_q);
         v = (k < 2) ? k[0] : lfsr_q[0];
         t = lfsr_q[7:4];
         comp_low_i <= v;
         wr(CTRL_ADDR, ctrl_exp(t, 1'b1, 1'b0));
         chk(detector_enable_o, 1'b1, "detector on");
         repeat (MIN_ON + 2) @(posedge clock_i);
         rd(IRQ_STAT_ADDR);
         chk(rdat, 32'h4, "settled");
         wr(CTRL_ADDR, ctrl_exp(t, 1'b0, 1'b0));
         comp_low_i <= ~v;
         @(posedge clock_i);
         chk(detector_enable_o, 1'b0, "detector off");
         rd(CTRL_ADDR);
         chk(rdat, ctrl_exp(t, 1'b0, v), "captured result");
         rd(IRQ_STAT_ADDR);
         chk(rdat, {29'h0, 1'b1, v, 1'b1}, "events");
         chk(irq_o, 1'b1, "irq raised");
         wr(IRQ_EN_ADDR, 32'h0);
         chk(irq_o, 1'b0, "irq masked");
         wr(IRQ_EN_ADDR, 32'h7);
         wr(CTRL_ADDR, ctrl_exp(t, 1'b0, 1'b1));
         rd(CTRL_ADDR);
         chk(rdat, ctrl_exp(t, 1'b0, v), "no recapture");
         wr(IRQ_CLR_ADDR, 32'h7);
         chk(irq_o, 1'b0, "irq cleared");
      end
      $display("test measure done");
      // heavy-load mode, unmapped address, dropped strobe
      wr(HEAVY_ADDR, 32'hff);
      chk(heavy_load_mode_o, 1'b1, "heavy on");
      rd(HEAVY_ADDR);
      chk(rdat, 32'h80, "heavy read");
      wr(HEAVY_ADDR, 32'h0);
      chk(heavy_load_mode_o, 1'b0, "heavy off");
      rd(32'h0003fc44);
      chk(rerr, 1'b1, "unmapped error");
      chk(rdat, 32'h0, "unmapped data");
      apb(1'b1, CTRL_ADDR, 32'h1f, 4'h0);
      rd(CTRL_ADDR);
      chk(rdat[4:0], {1'b0, t}, "strobe off");
      $display("test access done");
      // low result, then reset with detector and heavy mode on
      comp_low_i <= 1'b1;
      wr(CTRL_ADDR, 32'h15);
      repeat (MIN_ON + 2) @(posedge clock_i);
      wr(CTRL_ADDR, 32'h5);
      wr(CTRL_ADDR, 32'h15);
      wr(HEAVY_ADDR, 32'h80);
      rd(CTRL_ADDR);
      chk(rdat, 32'h35, "low before reset");
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      reset_check();
      give_verdict();
   end

endmodule : testbench

`default_nettype wire
